// >>> inc/fdc_pos_scan_params.svh
/*
 * Constants for the positioning and scan command engine: register
 * offsets, field positions, opcodes, step limits and timing figures.
 * Assumes a 10 MHz core clock and a byte-wide register port.
 */
`ifndef FDC_POS_SCAN_PARAMS_SVH
`define FDC_POS_SCAN_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses).
// ----------------------------------------------------------------------
`define REG_CMD        8'h00
`define REG_SEL        8'h04
`define REG_MODE       8'h08
`define REG_RATE       8'h0C
`define REG_RTN        8'h10
`define REG_SECT       8'h14
`define REG_EOT        8'h18
`define REG_SSTEP      8'h1C
`define REG_MSR        8'h20
`define REG_ST0        8'h24
`define REG_ST2        8'h28
`define REG_PTR        8'h2C
`define REG_SDATA      8'h30

// ----------------------------------------------------------------------
// Fields, opcodes and reset values.
// ----------------------------------------------------------------------
`define MODE_LONG      0
`define MODE_EXT       1
`define MODE_WILD      2
`define OP_DIR         6
`define OP_SKIP        5
`define OP_RECAL       8'h07
`define OP_REL_LOW     6'h0F
`define OP_SC_EQ       5'h11
`define OP_SC_LE       5'h19
`define OP_SC_HE       5'h1D
`define IC_NORMAL      3'h1
`define IC_ABN_SEEK    3'h3
`define IC_ABN_CMD     2'h1
`define RATE_RST       4'h8
`define EOT_RST        8'h12
`define SSTEP_RST      8'h01
`define WILD_BYTE      8'hFF
`define LIM_STD        12'd85
`define LIM_LONG       12'd255
`define LIM_EXT        12'd3925
`define LIM_BOTH       12'd4095

// ----------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------
`define CLK_NS         100
`define MOTOR_ON_US    500
`define STEP_UNIT_US   1000
`define PULSE_NS       1000
`define PULSE_CYC      ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> inc/fdc_pos_scan_pkg.sv
/*
 * Types for the positioning and scan command engine: states, scan
 * kinds, the register port carrier and the read channel carrier.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fdc_pos_scan_pkg;

    // ------------------------------------------------------------------
    // Engine states and scan kinds.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_MOTOR, ST_POLL, ST_SCAN} st_e;
    typedef enum logic [1:0] {SC_EQ, SC_LE, SC_HE} scan_e;

    // ------------------------------------------------------------------
    // Register port request and read channel byte stream.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_s;

    typedef struct packed {
        logic       vld;        // One disk data byte.
        logic [7:0] data;
        logic       sector_end; // Pulse after the last byte of a sector.
        logic       deleted;    // Sector carries a deleted-data mark.
        logic       err;        // Read error on this sector.
    } disk_s;

endpackage

// >>> rtl/fdc_pos_scan.sv
/*
 * Recalibrate, relative seek and scan command engine of a floppy
 * controller, with its registers on a plain strobe port.
 * Assumes the read channel runs on core_clk; drive pins are async.
 */
// Operation
// [R1] Recalibrate zeroes track, steps out to zero
// [R2] Recalibrate limit 85, 255, 3925, 4095
// [R3] Last command byte sets drive busy
// [R4] Motor-on wait, idle, then poll stepping
// [R5] Recalibrate end raises interrupt, no results
// [R6] Host repeats recalibrate for long drives
// [R7] Direction bit zero out, one in
// [R8] Relative seek issues exact count, updates track
// [R9] Track zero stops relative seek early
// [R10] Relative track update is modulo 255
// [R11] Relative seek busy, wait, step, interrupt
// [R12] Host runs one positioning command only
// [R13] Three scans: equal, low-equal, high-equal
// [R14] Compare most significant first, sector step
// [R15] Scan ends on hit, last sector, count
// [R16] Wildcard FFh byte always matches
// [R17] Read errors end scan as read does
// [R18] Skip deleted sectors; all skipped reports hit
// [R19] Scan equal status 10 hit, 01 miss
// [R20] Inequality scans 10 equal, 00 strict, 01
// [R21] Host supplies bytes compared against disk
// [R22] Steps paced at programmed step rate
// [R23] Seek end code 001 normal, 011 abnormal
// [R24] Opcode decode for all supported commands
`timescale 1ns/1ns
`include "fdc_pos_scan_params.svh"

module fdc_pos_scan
    import fdc_pos_scan_pkg::*;
#(
    parameter int MOTOR_ON_CYC  = (`MOTOR_ON_US * 1000 + `CLK_NS - 1) / `CLK_NS,
    parameter int STEP_UNIT_CYC = (`STEP_UNIT_US * 1000 + `CLK_NS - 1) / `CLK_NS
) (
    input  wire logic       core_clk,      // 10 MHz core clock.
    input  wire logic       rst_b,         // Async reset, active low.
    input  wire bus_s       bus,           // Register port request.
    output logic [7:0]      rdata,         // Read data, cycle after read.
    input  wire disk_s      disk,          // Read channel byte stream.
    input  wire logic       track_zero_in, // Drive at track zero pin.
    input  wire logic       terminal_count,// Terminal count pin.
    output logic            step_out,      // Step pulse to drive.
    output logic            dir_out,       // Step direction, 1 is inward.
    output logic            irq            // Interrupt, level.
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        st_e             st;
        logic            tz_m, tz, tc_m, tc;
        logic [7:0]      opcode;
        logic [2:0]      sel;
        logic [2:0]      mode;
        logic [3:0]      rate;
        logic [7:0]      relative_step_count, sect, last_sector_number, sstep, cur, hbyte, st0;
        logic [1:0]      st2;
        logic            hfull;
        logic [3:0]      busy;
        logic            cmd_busy;
        logic [3:0][11:0] ptr;
        logic [17:0]     tmr;
        logic [3:0]      pw;
        logic [11:0]     steps;
        logic            recal, dir, skip_en, any_read;
        logic [1:0]      drv;
        scan_e           stype;
        logic [1:0]      rel;
        logic            step, irq;
        logic [7:0]      rdata;
    } state_t;

    localparam logic [1:0] REL_EQ = 2'h0;
    localparam logic [1:0] REL_LT = 2'h1;
    localparam logic [1:0] REL_GT = 2'h2;
    localparam logic [3:0] PULSE  = 4'(`PULSE_CYC);

    state_t q, d;

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------

    // Step period in cycles; a rate of zero means sixteen units.
    function automatic logic [17:0] step_period(input logic [3:0] r);
        logic [4:0] u;
        u = (r == 4'h0) ? 5'h10 : {1'b0, r};
        return 18'(u * STEP_UNIT_CYC);
    endfunction

    // Recalibrate step limit from the two range bits.
    function automatic logic [11:0] recal_limit(input logic [2:0] m);
        case ({m[`MODE_EXT], m[`MODE_LONG]})
            2'b00:   return `LIM_STD;
            2'b01:   return `LIM_LONG;
            2'b10:   return `LIM_EXT;
            default: return `LIM_BOTH;
        endcase
    endfunction

    // Byte ordering of disk against host, wildcard aware.
    function automatic logic [1:0] cmp_byte(input logic [7:0] dk,
                                            input logic [7:0] hs,
                                            input logic       wild);
        if (wild && (dk == `WILD_BYTE || hs == `WILD_BYTE))
            return REL_EQ;                                   // [R16]
        if (dk == hs)
            return REL_EQ;
        return (dk < hs) ? REL_LT : REL_GT;
    endfunction

    // New track after a relative move, kept modulo 255.
    function automatic logic [7:0] rel_track(input logic [7:0] p,
                                             input logic [7:0] n,
                                             input logic       inward);
        logic [8:0] s;
        s = 9'h000;
        if (inward) begin
            s = {1'b0, p} + {1'b0, n};
            if (s >= 9'd255)
                s = s - 9'd255;
        end else begin
            s = (p >= n) ? ({1'b0, p} - {1'b0, n})
                         : ({1'b0, p} + 9'd255 - {1'b0, n});
        end
        return s[7:0];                                        // [R10]
    endfunction

    logic start_ok;
    logic is_recal, is_rel, is_scan;
    logic stop_pos, sec_met;
    logic [1:0] cmp_now;

    // Opcode decode of a command write; only taken while fully idle.
    assign start_ok = bus.wr && bus.addr == `REG_CMD
                      && q.st == ST_IDLE && q.busy == 4'h0;
    assign is_recal = bus.wdata == `OP_RECAL;                 // [R24]
    assign is_rel   = bus.wdata[7] && bus.wdata[5:0] == `OP_REL_LOW;
    assign is_scan  = bus.wdata[4:0] == `OP_SC_EQ
                      || bus.wdata[4:0] == `OP_SC_LE
                      || bus.wdata[4:0] == `OP_SC_HE;
    // Track zero only ends outward motion; inward it is meaningless.
    assign stop_pos = (q.tz && !q.dir)                        // [R9]
                      || (q.recal ? q.steps == recal_limit(q.mode)
                                  : q.steps == {4'h0, q.relative_step_count});
    assign cmp_now  = cmp_byte(disk.data, q.hbyte, q.mode[`MODE_WILD]);
    // The first differing byte decides, since bytes arrive MSB first.
    always_comb begin
        case (q.stype)                                        // [R13]
            SC_EQ:   sec_met = q.rel == REL_EQ;
            SC_LE:   sec_met = q.rel != REL_GT;
            SC_HE:   sec_met = q.rel != REL_LT;
            default: sec_met = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.tz_m  = track_zero_in;
        d.tz    = q.tz_m;
        d.tc_m  = terminal_count;
        d.tc    = q.tc_m;
        d.rdata = 8'h00;
        if (q.pw != 4'h0)
            d.pw = q.pw - 4'h1;

        // Register reads; the status read retires the interrupt.
        if (bus.rd) begin
            case (bus.addr)
                `REG_CMD:   d.rdata = q.opcode;
                `REG_SEL:   d.rdata = {5'h00, q.sel};
                `REG_MODE:  d.rdata = {5'h00, q.mode};
                `REG_RATE:  d.rdata = {4'h0, q.rate};
                `REG_RTN:   d.rdata = q.relative_step_count;
                `REG_SECT:  d.rdata = q.sect;
                `REG_EOT:   d.rdata = q.last_sector_number;
                `REG_SSTEP: d.rdata = q.sstep;
                `REG_MSR:   d.rdata = {q.st == ST_SCAN && !q.hfull,
                                       2'b00, q.cmd_busy, q.busy};
                `REG_ST0: begin
                    d.rdata = q.st0;
                    d.irq   = 1'b0;                           // [R23]
                end
                `REG_ST2:   d.rdata = {4'h0, q.st2, 2'b00};
                `REG_PTR:   d.rdata = q.ptr[q.sel[1:0]][7:0];
                `REG_SDATA: d.rdata = q.cur;
                default:    d.rdata = 8'h00;
            endcase
        end

        // Register writes and command launch.
        if (bus.wr) begin
            case (bus.addr)
                `REG_SEL:   d.sel   = bus.wdata[2:0];
                `REG_MODE:  d.mode  = bus.wdata[2:0];
                `REG_RATE:  d.rate  = bus.wdata[3:0];
                `REG_RTN:   d.relative_step_count   = bus.wdata;
                `REG_SECT:  d.sect  = bus.wdata;
                `REG_EOT:   d.last_sector_number   = bus.wdata;
                `REG_SSTEP: d.sstep = bus.wdata;
                `REG_SDATA: begin
                    d.hbyte = bus.wdata;                      // [R21]
                    d.hfull = 1'b1;
                end
                default: ;
            endcase
        end
        if (start_ok) begin
            d.opcode = bus.wdata;
            d.drv    = q.sel[1:0];
            d.steps  = 12'h000;
            if (is_recal || is_rel) begin
                d.busy[q.sel[1:0]] = 1'b1;                    // [R3] [R11]
                d.cmd_busy = 1'b1;
                d.recal    = is_recal;
                d.dir      = is_rel && bus.wdata[`OP_DIR];    // [R7]
                if (is_recal)
                    d.ptr[q.sel[1:0]] = 12'h000;              // [R1]
                d.tmr = 18'(MOTOR_ON_CYC - 1);                // [R4]
                d.st  = ST_MOTOR;
            end else if (is_scan) begin
                d.stype = (bus.wdata[4:0] == `OP_SC_EQ) ? SC_EQ :
                          (bus.wdata[4:0] == `OP_SC_LE) ? SC_LE : SC_HE;
                d.skip_en  = bus.wdata[`OP_SKIP];
                d.cur      = q.sect;
                d.rel      = REL_EQ;
                d.any_read = 1'b0;
                d.hfull    = 1'b0;
                d.cmd_busy = 1'b1;
                d.st       = ST_SCAN;
            end
        end

        case (q.st)
            ST_IDLE: ;
            // Motor-on wait, then the command phase ends and the drive
            // is stepped from the polling loop.
            ST_MOTOR: begin
                if (q.tmr == 18'h0) begin
                    d.cmd_busy = 1'b0;                        // [R4]
                    d.st       = ST_POLL;
                end else begin
                    d.tmr = q.tmr - 18'h1;
                end
            end
            // Each period either ends the move or issues one pulse; the
            // end is thus seen one full period after the last pulse.
            ST_POLL: begin
                if (q.tmr != 18'h0) begin
                    d.tmr = q.tmr - 18'h1;
                end else if (stop_pos) begin
                    d.busy[q.drv] = 1'b0;
                    d.irq = 1'b1;                             // [R5] [R11]
                    d.st0 = {(q.recal && !q.tz) ? `IC_ABN_SEEK
                                                : `IC_NORMAL,
                             3'b000, q.drv};                  // [R23]
                    if (!q.recal)
                        d.ptr[q.drv] = {4'h0, rel_track(
                            q.ptr[q.drv][7:0], q.steps[7:0],
                            q.dir)};                          // [R8] [R10]
                    d.st = ST_IDLE;
                end else begin
                    d.steps = q.steps + 12'h1;                // [R2] [R8]
                    d.pw    = PULSE;
                    d.tmr   = step_period(q.rate) - 18'h1;    // [R22]
                end
            end
            ST_SCAN: begin
                if (disk.vld) begin
                    if (!q.hfull) begin
                        // Host fell behind the disk: overrun abort.
                        d.st0 = {`IC_ABN_CMD, 4'h0, q.sel[1:0]};
                        d.st2 = 2'b00;
                        d.irq = 1'b1;
                        d.cmd_busy = 1'b0;
                        d.st = ST_IDLE;
                    end else begin
                        if (q.rel == REL_EQ)
                            d.rel = cmp_now;                  // [R14] [R21]
                        d.hfull = 1'b0;
                    end
                end else if (disk.sector_end) begin
                    d.rel = REL_EQ;
                    if (disk.err) begin
                        d.st0 = {`IC_ABN_CMD, 4'h0, q.sel[1:0]}; // [R17]
                        d.st2 = 2'b00;
                        d.irq = 1'b1;
                        d.cmd_busy = 1'b0;
                        d.st = ST_IDLE;
                    end else if (!(disk.deleted && q.skip_en) && sec_met)
                    begin
                        d.st0 = {2'b00, 4'h0, q.sel[1:0]};    // [R15]
                        d.st2 = (q.rel == REL_EQ) ? 2'b10
                                                  : 2'b00;    // [R19] [R20]
                        d.irq = 1'b1;
                        d.cmd_busy = 1'b0;
                        d.st = ST_IDLE;
                    end else if (q.cur >= q.last_sector_number || q.tc) begin
                        // All skipped reads as a hit; else a miss.
                        d.st0 = {2'b00, 4'h0, q.sel[1:0]};
                        d.st2 = 2'b01;
                        if (!q.any_read && disk.deleted && q.skip_en)
                            d.st2 = 2'b10;                    // [R18]
                        d.irq = 1'b1;
                        d.cmd_busy = 1'b0;
                        d.st = ST_IDLE;
                    end else begin
                        d.cur = q.cur + q.sstep;              // [R14]
                    end
                    if (!(disk.deleted && q.skip_en))
                        d.any_read = 1'b1;
                end
            end
            default: d.st = ST_IDLE;
        endcase
        d.step = d.pw != 4'h0;
    end

    // ------------------------------------------------------------------
    // Registers and outputs.
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q       <= '0;
            q.st    <= ST_IDLE;
            q.stype <= SC_EQ;
            q.rate  <= `RATE_RST;
            q.last_sector_number   <= `EOT_RST;
            q.sstep <= `SSTEP_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata    = q.rdata;
    assign step_out = q.step;
    assign dir_out  = q.dir;
    assign irq      = q.irq;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_recal_track_zero: assert property ( // [R1]
        start_ok && is_recal |=> q.ptr[q.drv] == 12'h000 && !q.dir)
        else $error("recalibrate did not clear track");
    a_recal_step_limit: assert property ( // [R2]
        q.st == ST_POLL && q.recal |-> q.steps <= recal_limit(q.mode))
        else $error("recalibrate exceeded step limit");
    a_busy_on_start: assert property ( // [R3]
        start_ok && (is_recal || is_rel) |=> q.busy[q.drv] && q.cmd_busy)
        else $error("drive busy not set");
    a_motor_no_step: assert property ( // [R4]
        q.st == ST_MOTOR |-> !q.step && q.cmd_busy)
        else $error("step during motor wait");
    a_seek_end_irq: assert property ( // [R5]
        q.st == ST_POLL ##1 q.st == ST_IDLE |-> q.irq && q.st0[5]
        && q.busy == 4'h0)
        else $error("seek end without interrupt");
    a_rel_dir_bit: assert property ( // [R7]
        start_ok && is_rel |=> q.dir == $past(bus.wdata[`OP_DIR]))
        else $error("direction bit misread");
    a_tz_stop: assert property ( // [R9]
        q.st == ST_POLL && q.tmr == 18'h0 && q.tz && !q.dir
        |=> q.st == ST_IDLE && !q.step)
        else $error("track zero did not stop stepping");
    a_step_width: assert property ( // [R22]
        $rose(q.step) |-> q.step [*8])
        else $error("step pulse too short");
    a_scan_status: assert property ( // [R19]
        q.st == ST_SCAN ##1 q.st == ST_IDLE |-> q.st2 != 2'b11 && q.irq)
        else $error("bad scan status");

    c_recal_done: cover property (q.st == ST_POLL && q.recal
                                  ##1 q.st == ST_IDLE);
    c_rel_done: cover property (q.st == ST_POLL && !q.recal
                                ##1 q.st == ST_IDLE);
    c_scan_hit: cover property (q.st == ST_SCAN ##1 q.st2 == 2'b10);

endmodule

// >>> sim/fdc_drive_model.sv
/*
 * Drive head model: moves the head on each step pulse and reports
 * track zero. Assumes step pulses are synchronous to core_clk.
 */
`timescale 1ns/1ns
module fdc_drive_model (
    input  wire logic core_clk,      // Core clock.
    input  wire logic step_out,      // Step pulse from the engine.
    input  wire logic dir_out,       // 1 steps inward.
    input  wire logic tz_broken,     // Sensor fault on command.
    output logic      track_zero_in, // Head at outermost track.
    output int        pulses         // Step pulses seen.
);
    int   pos;
    logic step_q = 1'b0;

    // The head moves on each rising step edge and stops at track 0.
    always @(posedge core_clk) begin
        step_q <= step_out;
        if (step_out && !step_q) begin
            pulses <= pulses + 1;
            if (dir_out)
                pos <= pos + 1;
            else if (pos > 0)
                pos <= pos - 1;
        end
    end

    // A faulty sensor never reports track 0, so limits can be reached.
    assign track_zero_in = !tz_broken && pos == 0;
endmodule

// >>> sim/fdc_pos_scan_test.sv
/*
 * Bench for the positioning and scan engine: drives the register
 * port and read channel and counts steps through a drive model.
 * Assumes short motor and step timing so each command ends quickly.
 */
`timescale 1ns/1ns
`include "fdc_pos_scan_params.svh"
module fdc_pos_scan_test;
    import fdc_pos_scan_pkg::*;
    logic       core_clk, rst_b, tz_broken, step_out, dir_out, irq, tz, tc;
    logic       wild = 1'b0;
    logic [7:0] rdata, v;
    bus_s       bus;
    disk_s      disk;
    int         mismatches, num_checks, cycles, seed, pulses, p0, n, h;

    fdc_pos_scan #(.MOTOR_ON_CYC(4), .STEP_UNIT_CYC(3)) u_fdc_pos_scan (
        .core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .disk(disk), .track_zero_in(tz), .terminal_count(tc),
        .step_out(step_out), .dir_out(dir_out), .irq(irq));
    fdc_drive_model u_fdc_drive_model (
        .core_clk(core_clk), .step_out(step_out), .dir_out(dir_out),
        .tz_broken(tz_broken), .track_zero_in(tz), .pulses(pulses));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // The longest command takes about 6100 cycles; stop a hang early.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // An idle cycle follows each access, so strobes never merge.
    task automatic acc(input logic w, input logic [7:0] a, d);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge core_clk);
        bus <= '0;
        // Read data stand until the next edge; sample them settled.
        #1 v = rdata;
        @(posedge core_clk);
    endtask

    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 8000) begin
            @(posedge core_clk);
            n++;
        end
        check(8'(irq), 8'h01);
    endtask

    task automatic pos_op(input logic [7:0] op, input int np,
                          input logic [7:0] st0);
        p0 = pulses;
        acc(1'b1, `REG_CMD, op);
        acc(1'b0, `REG_MSR, 8'h00);
        check(v & 8'h01, 8'h01);
        wait_irq();
        check(8'(pulses - p0), 8'(np));
        check(8'(dir_out), 8'(op[7] & op[6]));
        acc(1'b0, `REG_ST0, 8'h00);
        check(v, st0);
        check(8'(irq), 8'h00);
        acc(1'b0, `REG_PTR, 8'h00);
        $display("positioning op %h done", op);
    endtask

    function automatic logic [7:0] expect_scan(input logic [7:0] op, h, d);
        if (h == d || (wild && (h == 8'hFF || d == 8'hFF)))
            return 8'h2;
        if (op[3] && (op[2] ? d > h : d < h))
            return 8'h0;
        return 8'h1;
    endfunction

    task automatic scan(input logic [7:0] op, h, d, input logic del, err);
        logic [7:0] e;
        e = (del && op[5]) ? 8'h2 : expect_scan(op, h, d);
        acc(1'b1, `REG_CMD, op);
        acc(1'b1, `REG_SDATA, h);
        disk <= '{vld: 1'b1, data: d, default: '0};
        @(posedge core_clk);
        disk <= '{sector_end: 1'b1, deleted: del, err: err, default: '0};
        @(posedge core_clk);
        disk <= '0;
        wait_irq();
        acc(1'b0, `REG_ST2, 8'h00);
        if (!err) check(8'(v[3:2]), e);
        acc(1'b0, `REG_ST0, 8'h00);
        check(8'(v[7:6]), 8'(err));
        $display("scan op %h host %h disk %h done", op, h, d);
    endtask

    initial begin
        seed = 32'h83c9;
        bus = '0;
        disk = '0;
        tc = 1'b0;
        tz_broken = 1'b0;
        rst_b = 1'b0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        acc(1'b0, 8'hFC, 8'h00);
        check(v, 8'h00);
        // Relative seeks: inward, outward past track zero, full wrap.
        h = ($random(seed) & 15) + 1;
        acc(1'b1, `REG_RTN, 8'(h));
        pos_op(8'hCF, h, 8'h20);
        check(v, 8'(h));
        acc(1'b1, `REG_RTN, 8'(h + 3));
        pos_op(8'h8F, h, 8'h20);
        check(v, 8'h00);
        acc(1'b1, `REG_RTN, 8'hFF);
        pos_op(8'hCF, 255, 8'h20);
        check(v, 8'h00);
        // Head at 255: default limit, long range, then a dead sensor.
        pos_op(8'h07, 85, 8'h60);
        acc(1'b1, `REG_MODE, 8'h01);
        pos_op(8'h07, 170, 8'h20);
        check(v, 8'h00);
        tz_broken <= 1'b1;
        pos_op(8'h07, 255, 8'h60);
        tz_broken <= 1'b0;
        // Scans: each kind below, equal to and above the host byte.
        acc(1'b1, `REG_SECT, 8'h01);
        acc(1'b1, `REG_EOT, 8'h01);
        for (int i = 0; i < 9; i++) begin
            h = ($random(seed) & 8'h7E) + 1;
            scan(8'h11 | 8'(i % 3 * 8 - (i % 3 / 2) * 4), 8'(h),
                 8'(h + i / 3 - 1), 1'b0, 1'b0);
        end
        // Terminal count ends a missing scan before the last sector.
        acc(1'b1, `REG_EOT, 8'h05);
        tc <= 1'b1;
        repeat (3) @(posedge core_clk);
        scan(8'h11, 8'h12, 8'h34, 1'b0, 1'b0);
        tc <= 1'b0;
        acc(1'b1, `REG_EOT, 8'h01);
        acc(1'b1, `REG_MODE, 8'h04);
        wild = 1'b1;
        scan(8'h11, 8'h12, 8'hFF, 1'b0, 1'b0);
        scan(8'h19, 8'hFF, 8'h03, 1'b0, 1'b0);
        scan(8'h31, 8'h12, 8'h34, 1'b1, 1'b0);
        scan(8'h1D, 8'h12, 8'h34, 1'b0, 1'b1);
        print_verdict();
    end
endmodule
